// ===== sci_pkg.sv
// Contract
// R1: Serial clock rate is reference over two times (linear+1) times two to exponent.
// R2: Linear term comes from its own four-bit field and counts as value plus one.
// R3: Clear receiver-driven starts on transmit data; set starts on receive room.
// R4: Software must set master-select before using SPI; slave mode is invalid.
// R5: On transmit underrun send all-ones, or resend the last byte when repeat set.
// R6: Clock-phase clear samples on the leading edge; set samples on the second.
// R7: Clock-polarity clear gives a rising leading edge; set gives a falling one.
// R8: Transmit-idle flag is high only with empty transmit FIFO and no shifting.
// R9: Receive-valid flag is high whenever the receive FIFO holds a byte.
// R10: Receive-overrun sets on receive FIFO overflow; data register read clears it.
// R11: Writing stop-request issues a STOP; the bit clears when it completes.
// R12: Writing start-request issues a START or repeated START; then self-clears.
// R13: Writing send-byte transmits one byte; the bit clears when it completes.
// R14: Writing receive-byte clocks in one byte; the bit clears when it completes.
// R15: After each received byte drive ACK when ack-select set, NACK when clear.
`default_nettype none
package sci_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [15:0] IDX_SPI_STATUS = 16'h44a0;
	localparam logic [15:0] IDX_I2C_COMMAND = 16'h44a6;
	localparam logic [15:0] IDX_I2C_ACK = 16'h44a8;
	localparam logic [15:0] IDX_SPI_CONFIG = 16'h44ac;
	localparam logic [15:0] IDX_RATE_LINEAR = 16'h44b0;
	localparam logic [15:0] IDX_RATE_EXPONENT = 16'h44b2;
	localparam logic [15:0] IDX_DATA_PORT = 16'h44c0;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'h44c2;
	localparam logic [15:0] IDX_IRQ_MASK = 16'h44c4;
	localparam logic [15:0] IDX_MODE = 16'h44c6;
	// Config field positions
	localparam int CFG_POL = 0;
	localparam int CFG_PHA = 1;
	localparam int CFG_ORDER = 2;
	localparam int CFG_RPT = 3;
	localparam int CFG_MST = 4;
	localparam int CFG_RXDRV = 5;
	// Command field positions
	localparam int CMD_RECV = 0;
	localparam int CMD_SEND = 1;
	localparam int CMD_START = 2;
	localparam int CMD_STOP = 3;
	// Interrupt status positions
	localparam int EV_SPI_DONE = 0;
	localparam int EV_RX_OVR = 1;
	localparam int EV_I2C_DONE = 2;
	localparam int EV_I2C_NACK = 3;
	// Reset values and constants
	localparam logic [5:0] RST_SPI_CONFIG = 6'h00;
	localparam logic [3:0] RST_RATE = 4'h0;
	localparam logic [3:0] RST_I2C_CMD = 4'h0;
	localparam logic [3:0] RST_IRQ = 4'h0;
	localparam logic [7:0] BUSY_TOKEN = 8'hff;
	localparam logic [3:0] SPI_LAST_EDGE = 4'hf;
	localparam logic [3:0] I2C_ACK_BIT = 4'h8;
	typedef enum logic [0:0] {SPI_IDLE, SPI_SHIFT} sci_spi_state_t;
	typedef enum logic [1:0] {I2C_IDLE, I2C_START, I2C_STOP, I2C_BYTE} sci_i2c_state_t;
endpackage
`default_nettype wire

// ===== sci_rate_gen.sv
`default_nettype none
module sci_rate_gen import sci_pkg::*; (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Control
	input wire logic i_run,
	input wire logic [3:0] i_lin,
	input wire logic [3:0] i_exp,
	// Half-period enable
	output logic o_tick
);
	logic [19:0] count;
	logic [19:0] next_count;
	logic [19:0] limit;

	// Half period is (linear+1) * 2^exponent cycles; full period twice that
	assign limit = 20'(({16'h0000, i_lin} + 20'h0_0001) << i_exp) - 20'h0_0001; // [R1] [R2]
	assign o_tick = i_run && (count == limit);

	// Next count
	always_comb begin
		next_count = count + 20'h0_0001;
		if (!i_run || o_tick) begin
			next_count = 20'h0_0000;
		end
	end

	// Count register
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count <= 20'h0_0000;
		end else begin
			count <= next_count;
		end
	end

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	tick_spacing_a: assert property (o_tick && limit != 20'h0_0000 && i_run |=> !o_tick) // [R1]
		else $error("Rate tick repeated too soon");
endmodule
`default_nettype wire

// ===== sci_fifo.sv
`default_nettype none
module sci_fifo (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Write side
	input wire logic i_push,
	input wire logic [7:0] i_wdata,
	// Read side
	input wire logic i_pop,
	output logic [7:0] o_rdata,
	// Flags
	output logic o_empty,
	output logic o_full
);
	logic [7:0] mem [4];
	logic [1:0] wr_ptr;
	logic [1:0] rd_ptr;
	logic [2:0] count;
	logic [1:0] next_wr_ptr;
	logic [1:0] next_rd_ptr;
	logic [2:0] next_count;
	logic do_push;
	logic do_pop;

	assign o_empty = (count == 3'h0);
	assign o_full = (count == 3'h4);
	assign o_rdata = mem[rd_ptr];
	assign do_push = i_push && !o_full;
	assign do_pop = i_pop && !o_empty;

	// Pointer update
	always_comb begin
		next_wr_ptr = do_push ? wr_ptr + 2'h1 : wr_ptr;
		next_rd_ptr = do_pop ? rd_ptr + 2'h1 : rd_ptr;
		next_count = count + (do_push ? 3'h1 : 3'h0) - (do_pop ? 3'h1 : 3'h0);
	end

	// Pointer registers
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr <= 2'h0;
			rd_ptr <= 2'h0;
			count <= 3'h0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Storage, no reset needed
	always_ff @(posedge i_clock) begin
		if (do_push) begin
			mem[wr_ptr] <= i_wdata;
		end
	end
endmodule
`default_nettype wire

// ===== sci_serial_ctrl.sv
`default_nettype none
module sci_serial_ctrl import sci_pkg::*; (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [19:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Interrupt
	output logic o_irq,
	// SPI master pins
	output logic o_sclk,
	output logic o_mosi,
	output logic o_ss_n,
	input wire logic i_miso,
	// I2C pins, enable high pulls low
	input wire logic i_scl,
	output logic o_scl_oe,
	input wire logic i_sda,
	output logic o_sda_oe
);
	// Register state
	logic [5:0] spi_config, next_spi_config;
	logic [3:0] rate_linear, next_rate_linear;
	logic [3:0] rate_exponent, next_rate_exponent;
	logic [3:0] i2c_command, next_i2c_command;
	logic ack_select, next_ack_select;
	logic mode_i2c, next_mode_i2c;
	logic [3:0] irq_status, next_irq_status;
	logic [3:0] irq_mask, next_irq_mask;
	logic rx_overrun, next_rx_overrun;
	logic [31:0] prdata, next_prdata;
	// SPI state
	sci_spi_state_t spi_state, next_spi_state;
	logic [3:0] edge_cnt, next_edge_cnt;
	logic [7:0] tx_byte, next_tx_byte;
	logic [7:0] rx_sr, next_rx_sr;
	logic [7:0] last_byte, next_last_byte;
	logic sclk, next_sclk;
	logic mosi, next_mosi;
	// I2C state
	sci_i2c_state_t i2c_state, next_i2c_state;
	logic [1:0] phase, next_phase;
	logic [3:0] bitn, next_bitn;
	logic [7:0] i2c_sr, next_i2c_sr;
	logic i2c_send, next_i2c_send;
	logic scl_oe, next_scl_oe;
	logic sda_oe, next_sda_oe;
	// Synchronisers
	logic [1:0] miso_sync, sda_sync, scl_sync;
	// Interconnect
	logic tick, run;
	logic tx_empty, tx_full, rx_empty, rx_full;
	logic [7:0] tx_head, rx_head;
	logic spi_pop, spi_push, i2c_pop, i2c_push;
	logic [7:0] i2c_rx_data;
	logic [3:0] cmd_clr;
	logic i2c_done_ev, i2c_nack_ev;
	logic rx_push, tx_push, rx_pop;
	logic [7:0] rx_wdata;
	logic wr_acc, rd_acc, setup, mapped;
	logic spi_go, tx_idle;
	logic [3:0] events;

	// Byte address decode
	function automatic logic hit(input logic [19:0] a, input logic [15:0] idx);
		return a == {2'b00, idx, 2'b00};
	endfunction
	// Pick bit i of a byte in the configured order
	function automatic logic pick(input logic [7:0] b, input logic [2:0] i, input logic lsb);
		return lsb ? b[i] : b[3'd7 - i];
	endfunction

	// Bus strobes
	assign setup = i_psel && !i_penable;
	assign wr_acc = i_psel && i_penable && i_pwrite;
	assign rd_acc = i_psel && i_penable && !i_pwrite;
	assign mapped = hit(i_paddr, IDX_SPI_STATUS) || hit(i_paddr, IDX_I2C_COMMAND)
		|| hit(i_paddr, IDX_I2C_ACK) || hit(i_paddr, IDX_SPI_CONFIG)
		|| hit(i_paddr, IDX_RATE_LINEAR) || hit(i_paddr, IDX_RATE_EXPONENT)
		|| hit(i_paddr, IDX_DATA_PORT) || hit(i_paddr, IDX_IRQ_STATUS)
		|| hit(i_paddr, IDX_IRQ_MASK) || hit(i_paddr, IDX_MODE);
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !mapped;
	assign o_prdata = prdata;
	assign o_irq = |(irq_status & irq_mask);

	// FIFO traffic
	assign tx_push = wr_acc && hit(i_paddr, IDX_DATA_PORT);
	assign rx_pop = rd_acc && hit(i_paddr, IDX_DATA_PORT);
	assign rx_push = spi_push || i2c_push;
	assign rx_wdata = spi_push ? next_rx_sr : i2c_rx_data;
	assign tx_idle = tx_empty && (spi_state == SPI_IDLE); // [R8]
	assign run = (spi_state != SPI_IDLE) || (i2c_state != I2C_IDLE);
	assign events = {i2c_nack_ev, i2c_done_ev, rx_push && rx_full, spi_push};

	sci_rate_gen u_rate (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_run(run),
		.i_lin(rate_linear),
		.i_exp(rate_exponent),
		.o_tick(tick)
	);
	sci_fifo u_tx_fifo (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_push(tx_push),
		.i_wdata(i_pwdata[7:0]),
		.i_pop(spi_pop || i2c_pop),
		.o_rdata(tx_head),
		.o_empty(tx_empty),
		.o_full(tx_full)
	);
	sci_fifo u_rx_fifo (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_push(rx_push),
		.i_wdata(rx_wdata),
		.i_pop(rx_pop),
		.o_rdata(rx_head),
		.o_empty(rx_empty),
		.o_full(rx_full)
	);

	// Register file next values
	always_comb begin
		next_spi_config = spi_config;
		next_rate_linear = rate_linear;
		next_rate_exponent = rate_exponent;
		next_ack_select = ack_select;
		next_mode_i2c = mode_i2c;
		next_irq_mask = irq_mask;
		next_prdata = prdata;
		next_i2c_command = i2c_command & ~cmd_clr; // [R11] [R12] [R13] [R14]
		next_irq_status = irq_status;
		next_rx_overrun = rx_overrun;
		if (wr_acc) begin
			if (hit(i_paddr, IDX_SPI_CONFIG)) next_spi_config = i_pwdata[5:0];
			if (hit(i_paddr, IDX_RATE_LINEAR)) next_rate_linear = i_pwdata[3:0]; // [R2]
			if (hit(i_paddr, IDX_RATE_EXPONENT)) next_rate_exponent = i_pwdata[3:0]; // [R1]
			if (hit(i_paddr, IDX_I2C_COMMAND)) next_i2c_command = i_pwdata[3:0];
			if (hit(i_paddr, IDX_I2C_ACK)) next_ack_select = i_pwdata[0];
			if (hit(i_paddr, IDX_MODE)) next_mode_i2c = i_pwdata[0];
			if (hit(i_paddr, IDX_IRQ_MASK)) next_irq_mask = i_pwdata[3:0];
			if (hit(i_paddr, IDX_IRQ_STATUS)) next_irq_status = irq_status & ~i_pwdata[3:0];
		end
		// Events win over a clear in the same cycle
		next_irq_status = next_irq_status | events;
		if (rx_pop) next_rx_overrun = 1'b0;
		if (rx_push && rx_full) next_rx_overrun = 1'b1; // [R10]
		// Read data captured in the setup phase
		if (setup) begin
			next_prdata = 32'h0000_0000;
			if (hit(i_paddr, IDX_SPI_STATUS))
				next_prdata[3:0] = {tx_idle, !tx_full, !rx_empty, rx_overrun}; // [R8] [R9]
			if (hit(i_paddr, IDX_I2C_COMMAND)) next_prdata[3:0] = i2c_command;
			if (hit(i_paddr, IDX_I2C_ACK)) next_prdata[0] = ack_select;
			if (hit(i_paddr, IDX_SPI_CONFIG)) next_prdata[5:0] = spi_config;
			if (hit(i_paddr, IDX_RATE_LINEAR)) next_prdata[3:0] = rate_linear;
			if (hit(i_paddr, IDX_RATE_EXPONENT)) next_prdata[3:0] = rate_exponent;
			if (hit(i_paddr, IDX_DATA_PORT)) next_prdata[7:0] = rx_head;
			if (hit(i_paddr, IDX_IRQ_STATUS)) next_prdata[3:0] = irq_status;
			if (hit(i_paddr, IDX_IRQ_MASK)) next_prdata[3:0] = irq_mask;
			if (hit(i_paddr, IDX_MODE)) next_prdata[0] = mode_i2c;
		end
	end

	// Register file storage
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			spi_config <= RST_SPI_CONFIG;
			rate_linear <= RST_RATE;
			rate_exponent <= RST_RATE;
			i2c_command <= RST_I2C_CMD;
			ack_select <= 1'b0;
			mode_i2c <= 1'b0;
			irq_status <= RST_IRQ;
			irq_mask <= RST_IRQ;
			rx_overrun <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			spi_config <= next_spi_config;
			rate_linear <= next_rate_linear;
			rate_exponent <= next_rate_exponent;
			i2c_command <= next_i2c_command;
			ack_select <= next_ack_select;
			mode_i2c <= next_mode_i2c;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			rx_overrun <= next_rx_overrun;
			prdata <= next_prdata;
		end
	end

	// SPI start condition, gated by master mode
	assign spi_go = !mode_i2c && spi_config[CFG_MST] // [R4]
		&& (spi_config[CFG_RXDRV] ? !rx_full : !tx_empty); // [R3]

	// SPI engine next values
	always_comb begin
		logic lead;
		logic smp;
		logic [4:0] nxt;
		lead = 1'b0;
		smp = 1'b0;
		nxt = 5'h00;
		next_spi_state = spi_state;
		next_edge_cnt = edge_cnt;
		next_tx_byte = tx_byte;
		next_rx_sr = rx_sr;
		next_last_byte = last_byte;
		next_sclk = sclk;
		next_mosi = mosi;
		spi_pop = 1'b0;
		spi_push = 1'b0;
		case (spi_state)
			SPI_IDLE: begin
				next_sclk = spi_config[CFG_POL]; // [R7]
				if (spi_go) begin
					// Underrun sends the busy token or repeats the last byte
					next_tx_byte = !tx_empty ? tx_head
						: (spi_config[CFG_RPT] ? last_byte : BUSY_TOKEN); // [R5]
					next_last_byte = next_tx_byte;
					spi_pop = !tx_empty;
					next_edge_cnt = 4'h0;
					next_spi_state = SPI_SHIFT;
					if (!spi_config[CFG_PHA]) next_mosi = pick(next_tx_byte, 3'h0, spi_config[CFG_ORDER]);
				end
			end
			SPI_SHIFT: begin
				if (tick) begin
					lead = !edge_cnt[0];
					smp = lead ^ spi_config[CFG_PHA]; // [R6]
					nxt = {1'b0, edge_cnt} + 5'h01;
					next_sclk = ~sclk; // [R7]
					if (smp) begin
						next_rx_sr = spi_config[CFG_ORDER] ? {miso_sync[1], rx_sr[7:1]}
							: {rx_sr[6:0], miso_sync[1]};
					end else if (edge_cnt != SPI_LAST_EDGE) begin
						next_mosi = pick(tx_byte, nxt[3:1], spi_config[CFG_ORDER]);
					end
					next_edge_cnt = nxt[3:0];
					if (edge_cnt == SPI_LAST_EDGE) begin
						spi_push = 1'b1;
						next_spi_state = SPI_IDLE;
					end
				end
			end
			default: next_spi_state = SPI_IDLE;
		endcase
	end

	// SPI engine registers
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			spi_state <= SPI_IDLE;
			edge_cnt <= 4'h0;
			tx_byte <= 8'h00;
			rx_sr <= 8'h00;
			last_byte <= BUSY_TOKEN;
			sclk <= 1'b0;
			mosi <= 1'b0;
		end else begin
			spi_state <= next_spi_state;
			edge_cnt <= next_edge_cnt;
			tx_byte <= next_tx_byte;
			rx_sr <= next_rx_sr;
			last_byte <= next_last_byte;
			sclk <= next_sclk;
			mosi <= next_mosi;
		end
	end
	assign o_sclk = sclk;
	assign o_mosi = mosi;
	assign o_ss_n = (spi_state == SPI_IDLE);

	// I2C engine next values
	always_comb begin
		next_i2c_state = i2c_state;
		next_phase = phase;
		next_bitn = bitn;
		next_i2c_sr = i2c_sr;
		next_i2c_send = i2c_send;
		next_scl_oe = scl_oe;
		next_sda_oe = sda_oe;
		cmd_clr = 4'h0;
		i2c_pop = 1'b0;
		i2c_push = 1'b0;
		i2c_done_ev = 1'b0;
		i2c_nack_ev = 1'b0;
		i2c_rx_data = {i2c_sr[6:0], sda_sync[1]};
		case (i2c_state)
			I2C_IDLE: begin
				next_phase = 2'h0;
				next_bitn = 4'h0;
				if (mode_i2c) begin
					if (i2c_command[CMD_START]) begin
						next_i2c_state = I2C_START;
					end else if (i2c_command[CMD_STOP]) begin
						next_i2c_state = I2C_STOP;
					end else if (i2c_command[CMD_SEND] && !tx_empty) begin
						next_i2c_state = I2C_BYTE;
						next_i2c_send = 1'b1;
						next_i2c_sr = tx_head;
						i2c_pop = 1'b1;
					end else if (i2c_command[CMD_RECV]) begin
						next_i2c_state = I2C_BYTE;
						next_i2c_send = 1'b0;
					end
				end
			end
			I2C_START: begin
				if (tick) begin
					next_phase = phase + 2'h1;
					case (phase)
						2'h0: begin
							next_scl_oe = 1'b0;
							next_sda_oe = 1'b0;
						end
						2'h1: next_sda_oe = 1'b1;
						default: begin
							next_scl_oe = 1'b1;
							cmd_clr[CMD_START] = 1'b1; // [R12]
							i2c_done_ev = 1'b1;
							next_i2c_state = I2C_IDLE;
						end
					endcase
				end
			end
			I2C_STOP: begin
				if (tick) begin
					next_phase = phase + 2'h1;
					case (phase)
						2'h0: begin
							next_scl_oe = 1'b1;
							next_sda_oe = 1'b1;
						end
						2'h1: next_scl_oe = 1'b0;
						default: begin
							next_sda_oe = 1'b0;
							cmd_clr[CMD_STOP] = 1'b1; // [R11]
							i2c_done_ev = 1'b1;
							next_i2c_state = I2C_IDLE;
						end
					endcase
				end
			end
			I2C_BYTE: begin
				if (tick) begin
					next_phase = phase + 2'h1;
					case (phase)
						2'h0: begin
							next_scl_oe = 1'b1;
							if (bitn != I2C_ACK_BIT) next_sda_oe = i2c_send && !i2c_sr[7];
							else next_sda_oe = !i2c_send && ack_select; // [R15]
						end
						2'h1: next_scl_oe = 1'b0;
						2'h2: begin
							if (bitn != I2C_ACK_BIT && !i2c_send) next_i2c_sr = i2c_rx_data;
							if (bitn == I2C_ACK_BIT && i2c_send) i2c_nack_ev = sda_sync[1];
						end
						default: begin
							next_scl_oe = 1'b1;
							next_bitn = bitn + 4'h1;
							if (i2c_send) next_i2c_sr = {i2c_sr[6:0], 1'b0}; // [R13]
							if (bitn == I2C_ACK_BIT) begin
								next_sda_oe = 1'b0;
								cmd_clr[CMD_SEND] = i2c_send; // [R13]
								cmd_clr[CMD_RECV] = !i2c_send; // [R14]
								i2c_push = !i2c_send; // [R14]
								i2c_rx_data = i2c_sr;
								i2c_done_ev = 1'b1;
								next_i2c_state = I2C_IDLE;
							end
						end
					endcase
				end
			end
			default: next_i2c_state = I2C_IDLE;
		endcase
	end

	// I2C engine registers and input synchronisers
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			i2c_state <= I2C_IDLE;
			phase <= 2'h0;
			bitn <= 4'h0;
			i2c_sr <= 8'h00;
			i2c_send <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			miso_sync <= 2'b00;
			sda_sync <= 2'b11;
			scl_sync <= 2'b11;
		end else begin
			i2c_state <= next_i2c_state;
			phase <= next_phase;
			bitn <= next_bitn;
			i2c_sr <= next_i2c_sr;
			i2c_send <= next_i2c_send;
			scl_oe <= next_scl_oe;
			sda_oe <= next_sda_oe;
			miso_sync <= {miso_sync[0], i_miso};
			sda_sync <= {sda_sync[0], i_sda};
			scl_sync <= {scl_sync[0], i_scl};
		end
	end
	assign o_scl_oe = scl_oe;
	assign o_sda_oe = sda_oe;

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	sequence byte_end_s;
		i2c_state == I2C_BYTE && tick && phase == 2'h3 && bitn == I2C_ACK_BIT;
	endsequence
	idle_polarity_a: assert property (spi_state == SPI_IDLE |=> sclk == $past(spi_config[CFG_POL])) // [R7]
		else $error("SPI clock idle level wrong");
	tx_idle_busy_a: assert property (spi_state == SPI_SHIFT |-> !tx_idle) // [R8]
		else $error("Transmit idle while shifting");
	rx_valid_set_a: assert property (rx_push && rx_empty |=> !rx_empty) // [R9]
		else $error("Receive valid missing");
	overrun_set_a: assert property (rx_push && rx_full |=> rx_overrun) // [R10]
		else $error("Overrun not flagged");
	overrun_clear_a: assert property (rx_pop && !(rx_push && rx_full) |=> !rx_overrun) // [R10]
		else $error("Overrun not cleared by read");
	underrun_token_a: assert property (spi_state == SPI_IDLE && spi_go && tx_empty // [R5]
		&& !spi_config[CFG_RPT] |=> tx_byte == BUSY_TOKEN) else $error("Busy token not sent");
	tx_driven_start_a: assert property (spi_state == SPI_IDLE && !mode_i2c && spi_config[CFG_MST] // [R3]
		&& !spi_config[CFG_RXDRV] && !tx_empty |=> spi_state == SPI_SHIFT) else $error("No start");
	mode0_trailing_a: assert property (spi_state == SPI_SHIFT && tick && !spi_config[CFG_PHA] // [R6]
		&& edge_cnt[0] |=> rx_sr == $past(rx_sr)) else $error("Sampled on trailing edge");
	start_clear_a: assert property (i2c_state == I2C_START && tick && phase == 2'h2 // [R12]
		&& !wr_acc |=> !i2c_command[CMD_START] ##0 scl_oe) else $error("Start bit stuck");
	stop_clear_a: assert property (i2c_state == I2C_STOP && tick && phase == 2'h2 // [R11]
		&& !wr_acc |=> !i2c_command[CMD_STOP] && !sda_oe) else $error("Stop bit stuck");
	send_clear_a: assert property (byte_end_s and i2c_send && !wr_acc // [R13]
		|=> !i2c_command[CMD_SEND]) else $error("Send bit stuck");
	recv_clear_a: assert property (byte_end_s and !i2c_send && !wr_acc // [R14]
		|=> !i2c_command[CMD_RECV] && i2c_state == I2C_IDLE) else $error("Receive bit stuck");
	ack_drive_a: assert property (i2c_state == I2C_BYTE && !i2c_send && bitn == I2C_ACK_BIT // [R15]
		&& phase == 2'h1 |-> sda_oe == ack_select) else $error("Wrong acknowledge level");
endmodule
`default_nettype wire

// ===== sci_slave_model.sv
`default_nettype none
module sci_slave_model #(
	parameter logic [7:0] TX_BYTE = 8'h1d
) (
	// SPI wires
	input wire logic i_sclk,
	input wire logic i_mosi,
	input wire logic i_ss_n,
	// Mode the slave is set to
	input wire logic i_pol,
	input wire logic i_pha,
	// Reply and capture
	output logic o_miso,
	output logic [7:0] o_rx_byte
);
	logic [7:0] sh;
	logic [7:0] rx;
	logic first;
	int edges = 16;
	initial begin
		o_miso = 1'b0;
		o_rx_byte = 8'h00;
		first = 1'b0;
	end
	// Load the reply when selected; phase 0 shows the first bit at once
	always @(negedge i_ss_n) begin
		sh = TX_BYTE;
		first = i_pha;
		edges = 0;
		if (!i_pha) o_miso = sh[7];
	end
	// On release flip the line so stale data cannot pass
	always @(posedge i_ss_n) o_miso = ~o_miso;
	// Sixteen edges a frame; the last one may come together with the release of select
	always @(i_sclk) if (edges < 16) begin
		edges++;
		if ((i_sclk !== i_pol) ^ i_pha) begin
			rx = {rx[6:0], i_mosi};
			if (edges >= 15) o_rx_byte = rx;
		end else if (first) begin
			o_miso = sh[7];
			first = 1'b0;
		end else begin
			sh = sh << 1;
			o_miso = sh[7];
		end
	end
endmodule
`default_nettype wire

// ===== tb.sv
`default_nettype none
module tb import sci_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [5:0] cfg; logic [3:0] lin; logic [3:0] ex;} sci_row_t;
	localparam logic [7:0] REPLY = 8'h1d;
	logic clock = 1'b0;
	logic rst_n, psel, penable, pwrite, pol, pha, watch, seen, err, ord;
	logic [19:0] paddr;
	logic [31:0] pwdata, rd;
	logic [7:0] txb;
	wire logic [31:0] prdata;
	wire logic [7:0] mdl_rx;
	wire logic pready, pslverr, irq, sclk, mosi, ss_n, miso, scl_oe, sda_oe;
	int n_mismatch = 0;
	int total_checks = 0;
	int gap = 0;
	int run = 0;
	logic sclk_q = 1'b0;
	// Polarity and phase in all four combinations, LSB-first bit order in one row, and a rate set per row
	// Half periods stay at three cycles or more: sampled data lags two cycles in the synchroniser
	sci_row_t rows [5] = '{
		'{6'h10, 4'h5, 4'h0},
		'{6'h11, 4'h1, 4'h1},
		'{6'h12, 4'h2, 4'h0},
		'{6'h13, 4'h0, 4'h2},
		'{6'h14, 4'h3, 4'h0}};
	always #20 clock = ~clock;
	sci_serial_ctrl dut (.i_clock(clock), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .o_sclk(sclk), .o_mosi(mosi),
		.o_ss_n(ss_n), .i_miso(miso), .i_scl(~scl_oe), .o_scl_oe(scl_oe), .i_sda(~sda_oe),
		.o_sda_oe(sda_oe));
	sci_slave_model #(.TX_BYTE(REPLY)) model (.i_sclk(sclk), .i_mosi(mosi), .i_ss_n(ss_n),
		.i_pol(pol), .i_pha(pha), .o_miso(miso), .o_rx_byte(mdl_rx));
	// Cycles between serial clock edges, and whether the data line was driven
	always @(posedge clock) begin
		if (sclk !== sclk_q) begin
			gap = run;
			run = 1;
		end else run = run + 1;
		sclk_q = sclk;
		if (watch && sda_oe === 1'b1) seen = 1'b1;
	end
	function automatic logic [7:0] rev8(input logic [7:0] b);
		for (int i = 0; i < 8; i++) rev8[i] = b[7 - i];
	endfunction
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			n_mismatch++;
			final_report;
		end
	endtask
	// Read a register until the masked bits match, within a bound
	task automatic poll(input logic [15:0] idx, input logic [31:0] m, input logic [31:0] v);
		int k;
		for (k = 0; k < 500; k++) begin
			apb(1'b0, idx, '0);
			if ((rd & m) === v) break;
		end
		chk(rd & m, v);
		if (k == 500) final_report;
	endtask
	initial begin
		{rst_n, psel, penable, pwrite, pol, pha, watch, seen} = '0;
		paddr = '0;
		pwdata = '0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		// Reset values, read-only status and an unmapped word
		apb(1'b0, IDX_SPI_CONFIG, '0);
		chk(rd, '0);
		apb(1'b0, IDX_RATE_EXPONENT, '0);
		chk(rd, '0);
		apb(1'b0, IDX_I2C_COMMAND, '0);
		chk(rd, '0);
		apb(1'b1, IDX_SPI_STATUS, 32'h0000_000f);
		apb(1'b0, IDX_SPI_STATUS, '0);
		chk(rd, 32'h0000_000c);
		apb(1'b0, 16'h4400, '0);
		chk(rd | 32'(err), 32'h0000_0001);
		// One byte per row, compared at both ends of the link
		foreach (rows[i]) begin
			pol <= rows[i].cfg[CFG_POL];
			pha <= rows[i].cfg[CFG_PHA];
			ord = rows[i].cfg[CFG_ORDER];
			txb = 8'hc1 ^ 8'(i);
			apb(1'b1, IDX_RATE_LINEAR, 32'(rows[i].lin));
			apb(1'b1, IDX_RATE_EXPONENT, 32'(rows[i].ex));
			apb(1'b1, IDX_SPI_CONFIG, 32'(rows[i].cfg));
			apb(1'b1, IDX_DATA_PORT, 32'(txb));
			poll(IDX_SPI_STATUS, 32'h0000_000f, 32'h0000_000e);
			chk(32'(gap), (32'(rows[i].lin) + 1) << rows[i].ex);
			chk(32'(mdl_rx), 32'(ord ? rev8(txb) : txb));
			chk(32'(sclk), 32'(rows[i].cfg[CFG_POL]));
			apb(1'b0, IDX_DATA_PORT, '0);
			chk(rd, 32'(ord ? rev8(REPLY) : REPLY));
		end
		// Receiver-driven with no transmit data: busy tokens until the receive FIFO is full
		apb(1'b1, IDX_SPI_CONFIG, 32'h0000_0030);
		repeat (400) @(posedge clock);
		apb(1'b0, IDX_SPI_STATUS, '0);
		chk(rd, 32'h0000_000e);
		chk(32'(mdl_rx), 32'h0000_00ff);
		// A transmit-driven byte into the full receive FIFO overflows it
		apb(1'b1, IDX_SPI_CONFIG, 32'h0000_0010);
		apb(1'b1, IDX_DATA_PORT, 32'h0000_0033);
		poll(IDX_SPI_STATUS, 32'h0000_0009, 32'h0000_0009);
		@(negedge clock);
		chk(32'(irq), '0);
		apb(1'b1, IDX_IRQ_MASK, 32'(1 << EV_RX_OVR));
		@(negedge clock);
		chk(32'(irq), 32'h0000_0001);
		apb(1'b1, IDX_IRQ_STATUS, 32'h0000_000f);
		@(negedge clock);
		chk(32'(irq), '0);
		repeat (4) apb(1'b0, IDX_DATA_PORT, '0);
		chk(rd, 32'(REPLY));
		apb(1'b0, IDX_SPI_STATUS, '0);
		chk(rd, 32'h0000_000c);
		// Repeat mode resends the last byte on underrun until the receive FIFO is full
		apb(1'b1, IDX_DATA_PORT, 32'h0000_005a);
		apb(1'b1, IDX_SPI_CONFIG, 32'h0000_0038);
		repeat (400) @(posedge clock);
		apb(1'b0, IDX_SPI_STATUS, '0);
		chk(rd, 32'h0000_000e);
		apb(1'b0, IDX_IRQ_STATUS, '0);
		chk(rd, 32'h0000_0001);
		chk(32'(mdl_rx), 32'h0000_005a);
		// I2C commands clear themselves; the acknowledge follows ack_select
		apb(1'b1, IDX_MODE, 32'h0000_0001);
		apb(1'b1, IDX_I2C_COMMAND, 32'(1 << CMD_START));
		poll(IDX_I2C_COMMAND, 32'h0000_000f, '0);
		apb(1'b1, IDX_DATA_PORT, 32'h0000_0096);
		apb(1'b1, IDX_I2C_COMMAND, 32'(1 << CMD_SEND));
		poll(IDX_I2C_COMMAND, 32'h0000_000f, '0);
		for (int a = 0; a < 2; a++) begin
			apb(1'b1, IDX_I2C_ACK, 32'(a));
			seen = 1'b0;
			watch = 1'b1;
			apb(1'b1, IDX_I2C_COMMAND, 32'(1 << CMD_RECV));
			poll(IDX_I2C_COMMAND, 32'h0000_000f, '0);
			watch = 1'b0;
			chk(32'(seen), 32'(a));
		end
		apb(1'b1, IDX_I2C_COMMAND, 32'(1 << CMD_STOP));
		poll(IDX_I2C_COMMAND, 32'h0000_000f, '0);
		chk(32'({scl_oe, sda_oe}), '0);
		final_report;
	end
endmodule
`default_nettype wire
